// ### i2c_filter_smbus_ctrl.sv
// Glitch filter, stop holdoff, stop detect, range match and SMBus control
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`include "i2c_filter_map.svh"

module i2c_filter_stage (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       raw,
    input  wire logic [4:0] width,
    output logic            filtered
);
    logic       sync_a;
    logic       sync_b;
    logic [4:0] run;

    // Two-stage synchroniser, first stage feeds only the second
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sync_a <= 1'b1;
            sync_b <= 1'b1;
        end else begin
            sync_a <= raw;
            sync_b <= sync_a;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            filtered <= 1'b1;
            run      <= 5'h00;
        end else if (sync_b == filtered) begin
            run <= 5'h00;
        end else if (run >= width) begin
            filtered <= sync_b;
            run      <= 5'h00;
        end else begin
            run <= run + 5'h01;
        end
    end
endmodule // i2c_filter_stage

module i2c_filter_smbus_ctrl (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    input  wire logic       stop_request,
    input  wire logic       controller_busy,
    input  wire logic       byte_done,
    input  wire logic       addr_valid,
    input  wire logic [6:0] rx_addr,
    input  wire logic       rx_byte_done,
    output logic            stop_ack,
    output logic            scl_filtered,
    output logic            sda_filtered,
    output logic            addr_match,
    output logic            alert_match,
    output logic            ack_now,
    output logic            ack_value,
    output logic            irq
);
    i2c_filter_pkg::reg_req_s    req;
    i2c_filter_pkg::stop_state_e stop_state;
    logic [7:0]  flt_reg;
    logic [7:0]  smb_reg;
    logic [6:0]  range_addr;
    logic [6:0]  primary_addr;
    logic [15:0] low_timeout_value;
    logic        irq_en;
    logic        irq_pend;
    logic        transmit_ack_value;
    logic        range_en;
    logic        transfer_complete_flag;
    logic        tcf_seen;
    logic        scl_f;
    logic        sda_f;
    logic        scl_d;
    logic        sda_d;
    logic        stop_seen;
    logic [5:0]  div;
    logic        tick;
    logic [24:0] high_count;
    logic [24:0] threshold;
    logic        wr_flt;
    logic        wr_ctl;

    assign req       = '{write: reg_write, read: reg_read, addr: reg_addr, wdata: reg_wdata};
    assign wr_flt    = req.write && req.addr == `REG_GLITCH_FILTER_STOP;
    assign wr_ctl    = req.write && req.addr == `REG_CONTROLLER_LINK;
    // Low_timeout_value * 512 ticks is Low_timeout_value*512 clocks at full rate, 64 times that at the slow rate
    assign threshold = {low_timeout_value, 9'h000};

    i2c_filter_stage u_scl (
        .clk      (clk),
        .reset    (reset),
        .raw      (scl_in),
        .width    (flt_reg[4:0]),
        .filtered (scl_f)
    );
    i2c_filter_stage u_sda (
        .clk      (clk),
        .reset    (reset),
        .raw      (sda_in),
        .width    (flt_reg[4:0]),
        .filtered (sda_f)
    );

    // Stop condition: SDA rises while SCL high
    assign stop_seen = scl_f && scl_d && sda_f && !sda_d;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            scl_d        <= 1'b1;
            sda_d        <= 1'b1;
            scl_filtered <= 1'b1;
            sda_filtered <= 1'b1;
        end else begin
            scl_d        <= scl_f;
            sda_d        <= sda_f;
            scl_filtered <= scl_f;
            sda_filtered <= sda_f;
        end
    end

    // Filter and stop register; set wins over the clear
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            flt_reg <= `RESET_BYTE;
        end else begin
            if (wr_flt) begin
                flt_reg[`FLT_HOLDOFF_BIT] <= req.wdata[`FLT_HOLDOFF_BIT];
                flt_reg[`FLT_STOP_IE_BIT] <= req.wdata[`FLT_STOP_IE_BIT];
                flt_reg[4:0]              <= req.wdata[4:0];
            end
            if (stop_seen)
                flt_reg[`FLT_STOP_FLAG_BIT] <= 1'b1;
            else if (wr_flt && req.wdata[`FLT_STOP_FLAG_BIT])
                flt_reg[`FLT_STOP_FLAG_BIT] <= 1'b0;
        end
    end

    // Stop-mode handshake
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stop_state <= i2c_filter_pkg::ST_RUN;
            stop_ack   <= 1'b0;
        end else begin
            unique case (stop_state)
                i2c_filter_pkg::ST_RUN: begin
                    stop_ack <= 1'b0;
                    if (stop_request) begin
                        if (!flt_reg[`FLT_HOLDOFF_BIT] || !controller_busy || byte_done) begin
                            stop_state <= i2c_filter_pkg::ST_ACKED;
                            stop_ack   <= 1'b1;
                        end else begin
                            stop_state <= i2c_filter_pkg::ST_DRAIN;
                        end
                    end
                end
                i2c_filter_pkg::ST_DRAIN: begin
                    // wait for byte end; a withdrawn request goes back to run
                    if (!stop_request) begin
                        stop_state <= i2c_filter_pkg::ST_RUN;
                    end else if (byte_done || !controller_busy) begin
                        stop_state <= i2c_filter_pkg::ST_ACKED;
                        stop_ack   <= 1'b1;
                    end
                end
                i2c_filter_pkg::ST_ACKED: begin
                    if (!stop_request) begin
                        stop_state <= i2c_filter_pkg::ST_RUN;
                        stop_ack   <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Controller link register: enable, pending, transmit_ack_value, range mode, tcf
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_en   <= 1'b0;
            irq_pend <= 1'b0;
            transmit_ack_value     <= 1'b0;
            range_en <= 1'b0;
            transfer_complete_flag      <= 1'b0;
            tcf_seen <= 1'b0;
        end else begin
            if (wr_ctl) begin
                irq_en   <= req.wdata[`CTL_IRQ_EN_BIT];
                transmit_ack_value     <= req.wdata[`CTL_TRANSMIT_ACK_VALUE_BIT];
                range_en <= req.wdata[`CTL_RANGE_EN_BIT];
            end
            transfer_complete_flag      <= byte_done;
            tcf_seen <= byte_done && !transfer_complete_flag;
            // transfer event kept pending across stop
            // pending returns while stop flag and its interrupt enable are both set
            if ((tcf_seen && irq_en) ||
                (flt_reg[`FLT_STOP_FLAG_BIT] && flt_reg[`FLT_STOP_IE_BIT]))
                irq_pend <= 1'b1;
            else if (wr_ctl && req.wdata[`CTL_IRQ_PEND_BIT])
                irq_pend <= 1'b0;
        end
    end

    // Address registers and SMBus control fields
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            range_addr        <= 7'h00;
            primary_addr      <= 7'h00;
            low_timeout_value <= 16'h0000;
            smb_reg           <= `RESET_BYTE;
        end else if (req.write) begin
            if (req.addr == `REG_RANGE_SLAVE_ADDRESS)
                range_addr <= req.wdata[7:1];
            if (req.addr == `REG_PRIMARY_ADDRESS)
                primary_addr <= req.wdata[7:1];
            if (req.addr == `REG_LOW_TIMEOUT_HI)
                low_timeout_value[15:8] <= req.wdata;
            if (req.addr == `REG_LOW_TIMEOUT_LO)
                low_timeout_value[7:0] <= req.wdata;
            if (req.addr == `REG_SMBUS_CONTROL_STATUS) begin
                smb_reg[`SMB_FAST_ACK_ENABLE_BIT]   <= req.wdata[`SMB_FAST_ACK_ENABLE_BIT];
                smb_reg[`SMB_ALERT_BIT]  <= req.wdata[`SMB_ALERT_BIT];
                smb_reg[`SMB_TIMEOUT_CLOCK_SELECT_BIT] <= req.wdata[`SMB_TIMEOUT_CLOCK_SELECT_BIT];
            end
        end
    end

    // bus clock / 64 or full rate
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            div  <= 6'h00;
            tick <= 1'b0;
        end else begin
            div  <= div + 6'h01;
            tick <= smb_reg[`SMB_TIMEOUT_CLOCK_SELECT_BIT] || div == 6'(`TIMEOUT_SLOW_DIV - 1);
        end
    end

    // both lines high past threshold; flag clears itself
    // auto clear when bus leaves idle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            high_count <= 25'h0000000;
        end else if (!(scl_f && sda_f) || low_timeout_value == 16'h0000) begin
            high_count <= 25'h0000000;
        end else if (tick && high_count <= threshold) begin
            high_count <= high_count + 25'h0000001;
        end
    end

    // Address match outputs and fast ack path
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            addr_match  <= 1'b0;
            alert_match <= 1'b0;
            ack_now     <= 1'b0;
            ack_value   <= 1'b0;
            irq         <= 1'b0;
        end else begin
            // above primary, at or below range
            addr_match <= addr_valid && ((rx_addr == primary_addr) ||
                          (range_addr != 7'h00 && rx_addr == range_addr) ||
                          (range_en && range_addr != 7'h00 &&
                           rx_addr > primary_addr && rx_addr <= range_addr));
            alert_match <= addr_valid && smb_reg[`SMB_ALERT_BIT] &&
                           rx_addr == `ALERT_RESPONSE_ADDR;
            // fast ack uses transmit_ack_value write now, else next byte
            ack_now   <= smb_reg[`SMB_FAST_ACK_ENABLE_BIT] ? wr_ctl : rx_byte_done;
            ack_value <= wr_ctl ? req.wdata[`CTL_TRANSMIT_ACK_VALUE_BIT] : transmit_ack_value;
            irq       <= irq_pend && (irq_en || flt_reg[`FLT_STOP_IE_BIT]);
        end
    end

    // Read data one cycle after the strobe; unmapped read zero
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (req.read) begin
            unique case (req.addr)
                `REG_GLITCH_FILTER_STOP:   reg_rdata <= flt_reg;
                `REG_SMBUS_CONTROL_STATUS: reg_rdata <= {smb_reg[7:3],
                                                         high_count > threshold,
                                                         smb_reg[1:0]};
                `REG_RANGE_SLAVE_ADDRESS:  reg_rdata <= {range_addr, 1'b0};
                `REG_PRIMARY_ADDRESS:      reg_rdata <= {primary_addr, 1'b0};
                `REG_LOW_TIMEOUT_HI:       reg_rdata <= low_timeout_value[15:8];
                `REG_LOW_TIMEOUT_LO:       reg_rdata <= low_timeout_value[7:0];
                `REG_CONTROLLER_LINK:      reg_rdata <= {3'h0, transfer_complete_flag, range_en, transmit_ack_value,
                                                         irq_pend, irq_en};
                default:                   reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule // i2c_filter_smbus_ctrl

// ### i2c_filter_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef I2C_FILTER_MAP_SVH
`define I2C_FILTER_MAP_SVH
`define REG_GLITCH_FILTER_STOP    8'h06
`define REG_SMBUS_CONTROL_STATUS  8'h08
`define REG_RANGE_SLAVE_ADDRESS   8'h0C
`define REG_CONTROLLER_LINK       8'h0D
`define REG_PRIMARY_ADDRESS       8'h0E
`define REG_LOW_TIMEOUT_HI        8'h0A
`define REG_LOW_TIMEOUT_LO        8'h0B
`define FLT_HOLDOFF_BIT           7
`define FLT_STOP_FLAG_BIT         6
`define FLT_STOP_IE_BIT           5
`define SMB_FAST_ACK_ENABLE_BIT              7
`define SMB_ALERT_BIT             6
`define SMB_TIMEOUT_CLOCK_SELECT_BIT            4
`define SMB_HIGH_TO_BIT           2
`define CTL_IRQ_EN_BIT            0
`define CTL_IRQ_PEND_BIT          1
`define CTL_TRANSMIT_ACK_VALUE_BIT              2
`define CTL_RANGE_EN_BIT          3
`define CTL_TCF_BIT               4
`define RESET_BYTE                8'h00
`define ALERT_RESPONSE_ADDR       7'h0C
`define TIMEOUT_SLOW_DIV          64
`define HIGH_TIMEOUT_SHIFT        9
`endif

// ### i2c_filter_pkg.sv
// Types shared by the filter and SMBus control block
package i2c_filter_pkg;
    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;
    typedef enum logic [2:0] {
        ST_RUN   = 3'b001,
        ST_DRAIN = 3'b010,
        ST_ACKED = 3'b100
    } stop_state_e;
endpackage

// ### i2c_filter_smbus_ctrl_props.sv
// Port-level timing checker for the filter and SMBus control block
`timescale 1ns/1ps
module i2c_filter_smbus_ctrl_props (
    input wire logic       clk,
    input wire logic       reset,
    input wire logic       reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_write,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       stop_request,
    input wire logic       controller_busy,
    input wire logic       byte_done,
    input wire logic       addr_valid,
    input wire logic       rx_byte_done,
    input wire logic       stop_ack,
    input wire logic       scl_filtered,
    input wire logic       sda_filtered,
    input wire logic       addr_match,
    input wire logic       alert_match,
    input wire logic       ack_now
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    // Stop request while idle, and while the last byte ends
    sequence s_idle_req; stop_request && !controller_busy; endsequence
    sequence s_byte_req; stop_request && byte_done; endsequence

    property p_ack_idle; s_idle_req |=> stop_ack; endproperty
    a_ack_idle: assert property (p_ack_idle) else $error("idle stop not acked");
    property p_ack_byte; s_byte_req |=> stop_ack; endproperty
    a_ack_byte: assert property (p_ack_byte) else $error("stop ack late");
    property p_ack_drop; !stop_request |=> !stop_ack; endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("stop ack stuck");

    // Filtered edge: raw line four samples back already held the new level
    property p_scl_flt; $changed(scl_filtered) |-> $past(scl_in, 4) == scl_filtered; endproperty
    a_scl_flt: assert property (p_scl_flt) else $error("clock glitch passed");
    property p_sda_flt; $changed(sda_filtered) |-> $past(sda_in, 4) == sda_filtered; endproperty
    a_sda_flt: assert property (p_sda_flt) else $error("data glitch passed");

    property p_match; addr_match |-> $past(addr_valid); endproperty
    a_match: assert property (p_match) else $error("match without address");
    property p_alert; alert_match |-> $past(addr_valid); endproperty
    a_alert: assert property (p_alert) else $error("alert without address");
    property p_ack_src; ack_now |-> $past(reg_write) || $past(rx_byte_done); endproperty
    a_ack_src: assert property (p_ack_src) else $error("ack without cause");
    property p_rd_idle; !$past(reg_read) |-> reg_rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
endmodule // i2c_filter_smbus_ctrl_props

// ### i2c_bus_partner.sv
// Far-side bus agent: pulls SCL or SDA low, pull-up restores them
`timescale 1ns/1ps
module i2c_bus_partner (
    input  wire logic clk,
    output logic      scl,
    output logic      sda
);
    // Released lines sit at the pull-up level
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    // Low pulse of n cycles; on SDA with SCL high it is start then stop
    task automatic pulse(input logic on_sda, input int n);
        @(posedge clk);
        if (on_sda) sda <= 1'b0;
        else scl <= 1'b0;
        repeat (n) @(posedge clk);
        sda <= 1'b1;
        scl <= 1'b1;
    endtask
endmodule // i2c_bus_partner

// ### test_i2c_filter_smbus_ctrl.sv
// Self-checking bench for the filter and SMBus control block
`timescale 1ns/1ps
`include "i2c_filter_map.svh"
module test_i2c_filter_smbus_ctrl;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic        stop_request = 1'b0;
    logic        controller_busy = 1'b0;
    logic [2:0]  kick = 3'h0;
    logic [6:0]  rx_addr = 7'h00;
    logic [7:0]  reg_rdata;
    logic        scl_in, sda_in, stop_ack, scl_filtered, sda_filtered;
    logic        addr_match, alert_match, ack_now, ack_value, irq;
    logic        got, last, low_seen, rm, al;
    logic [31:0] seed = 32'h000084D3;
    logic [31:0] v;
    logic [6:0]  pa, ra, a;
    int          n_fail = 0;
    int          n_checks = 0;
    int          cycles = 0;
    int          n;
    int          widths [4] = '{0, 1, 5, 31};

    always #10 clk = ~clk;

    i2c_filter_smbus_ctrl i2c_filter_smbus_ctrl_i (.clk, .reset, .reg_addr, .reg_wdata,
        .reg_write, .reg_read, .reg_rdata, .scl_in, .sda_in, .stop_request, .controller_busy,
        .byte_done(kick[0]), .addr_valid(kick[1]), .rx_addr, .rx_byte_done(kick[2]), .stop_ack,
        .scl_filtered, .sda_filtered, .addr_match, .alert_match, .ack_now, .ack_value, .irq);
    i2c_bus_partner i2c_bus_partner_i (.clk, .scl(scl_in), .sda(sda_in));

    // Monitors latch single-cycle outputs; cycle ceiling cuts a hang
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (ack_now) got <= 1'b1;
        if (ack_now) last <= ack_value;
        if (!scl_filtered || !sda_filtered) low_seen <= 1'b1;
        if (cycles == 80000) begin
            n_fail++;
            results();
        end
    end

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function logic match_exp(input logic [6:0] x, p, r, input logic m);
        return x == p || (r != 7'h00 && (x == r || (m && x > p && x <= r)));
    endfunction

    task chk(input logic [7:0] g, e);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask

    task wr(input logic [7:0] ad, d);
        @(posedge clk);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    task rd(input logic [7:0] ad, m, e);
        @(posedge clk);
        reg_addr <= ad;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 chk(reg_rdata & m, e);
    endtask

    task pulse(input int i);
        @(posedge clk);
        kick[i] <= 1'b1;
        @(posedge clk);
        kick[i] <= 1'b0;
        #1;
    endtask

    task results();
        if (n_fail == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        // Reset values; unmapped place ignores writes
        wr(8'h3F, 8'hFF);
        rd(`REG_GLITCH_FILTER_STOP, 8'hFF, 8'h00);
        rd(`REG_SMBUS_CONTROL_STATUS, 8'hFF, 8'h00);
        rd(`REG_RANGE_SLAVE_ADDRESS, 8'hFF, 8'h00);
        rd(8'h3F, 8'hFF, 8'h00);
        v = rnd();
        wr(`REG_RANGE_SLAVE_ADDRESS, v[7:0] | 8'h01);
        rd(`REG_RANGE_SLAVE_ADDRESS, 8'hFF, v[7:0] & 8'hFE);
        // Address match in four setups: alert off/on, range off/on, empty range
        for (int k = 0; k < 40; k++) begin
            if (k % 10 == 0) begin
                v = rnd();
                pa = v[6:0] | 7'h01;
                ra = (k == 30) ? 7'h00 : v[14:8];
                al = k[0] ^ (k % 20 != 0);
                rm = k != 0;
                wr(`REG_PRIMARY_ADDRESS, {pa, 1'b0});
                wr(`REG_RANGE_SLAVE_ADDRESS, {ra, 1'b0});
                wr(`REG_CONTROLLER_LINK, {4'h0, rm, 3'h0});
                wr(`REG_SMBUS_CONTROL_STATUS, {1'b0, al, 6'h00});
            end
            v = rnd();
            case (k % 10)
                0: a = pa;
                1: a = pa + 7'h01;
                2: a = ra;
                3: a = ra + 7'h01;
                4: a = `ALERT_RESPONSE_ADDR;
                // own address follows an alert reply
                5: a = pa;
                default: a = v[6:0];
            endcase
            rx_addr <= a;
            pulse(1);
            chk(addr_match, match_exp(a, pa, ra, rm));
            chk(alert_match, al && a == `ALERT_RESPONSE_ADDR);
        end
        // Stop acknowledge for each holdoff and busy setting
        for (int i = 0; i < 4; i++) begin
            wr(`REG_GLITCH_FILTER_STOP, {i[1], 7'h00});
            controller_busy <= i[0];
            @(posedge clk);
            stop_request <= 1'b1;
            @(posedge clk);
            #1 chk(stop_ack, !(i[1] && i[0]));
            if (i == 3) begin
                repeat (3) @(posedge clk);
                #1 chk(stop_ack, 1'b0);
                pulse(0);
                chk(stop_ack, 1'b1);
            end
            stop_request <= 1'b0;
            controller_busy <= 1'b0;
            @(posedge clk);
            #1 chk(stop_ack, 1'b0);
            // cut transfer restarts by resending the address
            if (i == 1) begin
                rx_addr <= pa;
                pulse(1);
                chk(addr_match, 1'b1);
            end
        end
        // Transfer-complete interrupt reaches software
        wr(`REG_CONTROLLER_LINK, 8'h01);
        pulse(0);
        repeat (2) @(posedge clk);
        #1 chk(irq, 1'b1);
        wr(`REG_CONTROLLER_LINK, 8'h02);
        // Glitch of width n is absorbed, width n+1 passes, on each line
        for (int w = 0; w < 8; w++) begin
            wr(`REG_GLITCH_FILTER_STOP, 8'(widths[w / 2]));
            repeat (40) @(posedge clk);
            low_seen = 1'b0;
            if (widths[w / 2] != 0) i2c_bus_partner_i.pulse(w[0], widths[w / 2]);
            repeat (40) @(posedge clk);
            #1 chk(low_seen, 1'b0);
            low_seen = 1'b0;
            i2c_bus_partner_i.pulse(w[0], widths[w / 2] + 1);
            repeat (40) @(posedge clk);
            #1 chk(low_seen, 1'b1);
        end
        // Stop flag, its interrupt enable and the clear order
        wr(`REG_GLITCH_FILTER_STOP, 8'h40);
        wr(`REG_CONTROLLER_LINK, 8'h02);
        rd(`REG_GLITCH_FILTER_STOP, 8'hFF, 8'h00);
        wr(`REG_GLITCH_FILTER_STOP, 8'h20);
        i2c_bus_partner_i.pulse(1'b1, 4);
        repeat (10) @(posedge clk);
        rd(`REG_GLITCH_FILTER_STOP, 8'hFF, 8'h60);
        chk(irq, 1'b1);
        wr(`REG_CONTROLLER_LINK, 8'h02);
        rd(`REG_CONTROLLER_LINK, 8'h02, 8'h02);
        wr(`REG_GLITCH_FILTER_STOP, 8'h60);
        wr(`REG_CONTROLLER_LINK, 8'h02);
        rd(`REG_CONTROLLER_LINK, 8'h02, 8'h00);
        chk(irq, 1'b0);
        wr(`REG_GLITCH_FILTER_STOP, 8'h40);
        i2c_bus_partner_i.pulse(1'b1, 4);
        repeat (10) @(posedge clk);
        chk(irq, 1'b0);
        // Acknowledge value with fast acknowledge off and on
        for (int i = 0; i < 4; i++) begin
            wr(`REG_SMBUS_CONTROL_STATUS, {i[1], 7'h00});
            #1 got = 1'b0;
            wr(`REG_CONTROLLER_LINK, {5'h00, i[0], 2'h0});
            repeat (2) @(posedge clk);
            #1 chk({got, last & i[1]}, {i[1], i[0] & i[1]});
            if (!i[1]) pulse(2);
            repeat (2) @(posedge clk);
            #1 chk({got, last}, {1'b1, i[0]});
        end
        // Idle-high timeout at both counter rates, threshold 512 ticks
        wr(`REG_LOW_TIMEOUT_HI, 8'h00);
        wr(`REG_LOW_TIMEOUT_LO, 8'h01);
        wr(`REG_GLITCH_FILTER_STOP, 8'h00);
        // fast rate run proves the counter only
        for (int s = 0; s < 2; s++) begin
            n = s ? 512 : 512 * `TIMEOUT_SLOW_DIV;
            wr(`REG_SMBUS_CONTROL_STATUS, {3'h0, s[0], 4'h0});
            i2c_bus_partner_i.pulse(1'b1, 2);
            repeat (n - n / 4) @(posedge clk);
            rd(`REG_SMBUS_CONTROL_STATUS, 8'h04, 8'h00);
            repeat (n / 2) @(posedge clk);
            rd(`REG_SMBUS_CONTROL_STATUS, 8'h04, 8'h04);
            i2c_bus_partner_i.pulse(1'b1, 2);
            // Let the low level through synchroniser and filter first
            repeat (4) @(posedge clk);
            rd(`REG_SMBUS_CONTROL_STATUS, 8'h04, 8'h00);
        end
        results();
    end
endmodule // test_i2c_filter_smbus_ctrl

bind i2c_filter_smbus_ctrl i2c_filter_smbus_ctrl_props props_i (.clk, .reset, .reg_read,
    .reg_rdata, .reg_write, .scl_in, .sda_in, .stop_request, .controller_busy, .byte_done,
    .addr_valid, .rx_byte_done, .stop_ack, .scl_filtered, .sda_filtered, .addr_match,
    .alert_match, .ack_now);
